// file: logic/por_boot_pkg.sv
// Purpose: constants and types for the power-on reset and boot status block
// Assumes: 100 MHz core_clk, APB register access
// Notes: supply-valid levels arrive already compared against their thresholds
package por_boot_pkg;
   localparam logic [11:0] raw_status_five_boot_addr = 12'hd23; // printed index
   localparam logic [11:0] pin_ctrl_addr = 12'h100;              // pin override register index
   localparam logic [11:0] pin_five_ctrl_addr = 12'h101;         // always-on pin five register
   localparam logic [11:0] soft_reset_addr = 12'h000;            // any write resets once booted
   localparam int boot_flag_bit = 8;
   localparam int pin_ctrl_boot_route_bit = 0; // route boot flag to a general pin
   localparam int pin_ctrl_out_bit = 1;        // general pin one as output
   localparam int pin_ctrl_irq_mask_bit = 2;   // mask boot flag from irq
   localparam int pin_ctrl_dmic_bit = 3;       // dual mic pins in digital function
   localparam logic [3:0] pin_ctrl_reset = 4'h0;
   localparam logic [1:0] pin_five_reset = 2'h0;
   localparam int boot_time_ns = 10000;
   localparam int clk_period_ns = 10;
   localparam logic [15:0] boot_cycles = 16'((boot_time_ns + clk_period_ns - 1) / clk_period_ns);
   typedef enum logic [1:0] {
      st_reset = 2'b00,
      st_boot = 2'b01,
      st_run = 2'b11,
      st_sleep = 2'b10
   } power_state_t;
endpackage

// file: logic/power_on_reset_boot_status.sv
// Purpose: power-on reset, sleep detection, boot status and pin defaults
// Assumes: supply good inputs synchronous to core_clk; APB slave, word addressed
// Notes: always-on state survives sleep and wake, nothing survives power-on
//
// The APB register port was decided locally.
`timescale 1ns/100ps
module power_on_reset_boot_status
   import por_boot_pkg::*;
(
   input wire logic core_clk, // 100 MHz clock
   input wire logic srst, // synchronous reset, high
   input wire logic clk_en, // freezes all state when low
   input wire logic analog_supply_ok, // analog supply above threshold
   input wire logic io_supply_one_ok, // io supply one above threshold
   input wire logic core_supply_ok, // core supply above threshold
   input wire logic hw_reset_n, // hardware reset pin, low active
   input wire logic control_port_mode_pin, // control port mode level
   input wire logic [13:0] paddr, // apb byte address
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   output logic core_reset, // digital core held in reset
   output logic sleep_mode, // device in sleep
   output logic boot_complete_flag, // boot done status
   output logic irq_n, // interrupt request pin level
   output logic general_pin_one_out, // general pin one output value
   output logic general_pin_one_oe, // general pin one drives
   output logic [2:0] general_pins_pd, // pull-downs on general pins one to three
   output logic general_pin_five_pd, // pull-down on general pin five
   output logic general_pin_five_oe, // general pin five drives
   output logic [3:0] jtag_pd, // pull-downs tck tdi tms trst
   output logic regulator_enable_pin_pd, // pull-down on regulator enable
   output logic reset_pin_pu, // pull-up on reset pin
   output logic control_port_select_pin_pd, // pull-down on select pin
   output logic mic_dual_digital // dual mic pins in digital function
);
   typedef struct packed {
      power_state_t state;
      logic powered;
      logic [15:0] count;
      logic flag;
      logic [3:0] pin_ctrl;
      logic [1:0] pin_five;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq_n;
      logic gp1_out;
      logic gp1_oe;
      logic [2:0] gp_pd;
      logic gp5_pd;
      logic gp5_oe;
      logic sel_pd;
      logic dmic;
      logic core_reset;
      logic sleep;
   } state_t;

   state_t s_reg;
   state_t s_next;
   logic [11:0] index;
   logic access;
   logic wr_soft;
   logic supplies_ok;
   logic sleep_cond;

   // word index decode from the byte address
   function automatic logic hit(input logic [11:0] idx);
      return (idx == raw_status_five_boot_addr) || (idx == pin_ctrl_addr) ||
             (idx == pin_five_ctrl_addr) || (idx == soft_reset_addr);
   endfunction

   assign index = paddr[13:2];
   assign access = psel && penable && !s_reg.pready;
   assign supplies_ok = analog_supply_ok && io_supply_one_ok && core_supply_ok;
   assign sleep_cond = analog_supply_ok && io_supply_one_ok && !core_supply_ok;
   // soft reset ignored until booted, so writes before boot cannot cut a boot short
   assign wr_soft = access && pwrite && (index == soft_reset_addr) && (s_reg.state == st_run);

   // next state of the whole block
   always_comb begin
      s_next = s_reg;
      s_next.pready = 1'b0;
      s_next.pslverr = 1'b0;
      case (s_reg.state)
         st_reset: begin
            s_next.flag = 1'b0;
            if (supplies_ok && hw_reset_n) begin
               s_next.state = st_boot;
               s_next.count = 16'h0000;
            end else if (s_reg.powered && sleep_cond) begin
               s_next.state = st_sleep;
            end
         end
         st_boot: begin
            s_next.count = s_reg.count + 16'h0001;
            if (s_reg.count == boot_cycles - 16'h0001) begin
               s_next.state = st_run;
               s_next.flag = 1'b1;
               s_next.powered = 1'b1;
            end
         end
         st_run: begin
            // flag drops with the state so core_reset never shows beside a set flag
            if (wr_soft) begin
               s_next.state = st_reset;
               s_next.flag = 1'b0;
            end
         end
         st_sleep: begin
            s_next.flag = 1'b0;
            if (supplies_ok) begin
               s_next.state = st_boot;
               s_next.count = 16'h0000;
            end
         end
         default: s_next.state = st_reset;
      endcase
      // hardware reset, or core supply drop once powered, leaves boot or run
      if (s_reg.state == st_boot || s_reg.state == st_run) begin
         if (!hw_reset_n) begin
            s_next.state = st_reset;
            s_next.flag = 1'b0;
         end else if (sleep_cond && s_reg.powered) begin
            s_next.state = st_sleep;
            s_next.flag = 1'b0;
         end
      end
      // analog or io one loss always reruns power-on reset, always-on lost too
      if (!analog_supply_ok || !io_supply_one_ok) begin
         s_next.state = st_reset;
         s_next.powered = 1'b0;
         s_next.flag = 1'b0;
         s_next.pin_five = pin_five_reset;
      end
      // pin_ctrl defaults on any reset and on sleep; always-on pin five is kept, only rail loss clears it
      if (s_next.state == st_reset || s_next.state == st_sleep) begin
         s_next.pin_ctrl = pin_ctrl_reset;
      end
      // apb slave: one answer with a single wait state after setup
      if (access) begin
         s_next.pready = 1'b1;
         s_next.pslverr = !hit(index);
         s_next.prdata = 32'h0000_0000;
         if (!pwrite) begin
            if (index == raw_status_five_boot_addr) begin
               s_next.prdata[boot_flag_bit] = s_reg.flag;
            end else if (index == pin_ctrl_addr) begin
               s_next.prdata[3:0] = s_reg.pin_ctrl;
            end else if (index == pin_five_ctrl_addr) begin
               s_next.prdata[1:0] = s_reg.pin_five;
            end
         end else if (s_reg.state == st_run || s_reg.state == st_boot) begin
            // boot sequence writes land here too and override defaults
            if (index == pin_ctrl_addr) begin
               s_next.pin_ctrl = pwdata[3:0];
            end else if (index == pin_five_ctrl_addr) begin
               s_next.pin_five = pwdata[1:0];
            end
         end
      end
      // pin outputs, registered so every output except the fixed pulls comes from a flop
      s_next.core_reset = (s_next.state == st_reset) || (s_next.state == st_sleep);
      s_next.sleep = (s_next.state == st_sleep);
      s_next.irq_n = !(s_next.flag && !s_next.pin_ctrl[pin_ctrl_irq_mask_bit]);
      s_next.gp1_oe = s_next.pin_ctrl[pin_ctrl_out_bit];
      s_next.gp1_out = s_next.pin_ctrl[pin_ctrl_boot_route_bit] && s_next.flag;
      s_next.gp_pd = {3{!s_next.pin_ctrl[pin_ctrl_out_bit]}};
      s_next.gp5_oe = s_next.pin_five[0];
      s_next.gp5_pd = !s_next.pin_five[0];
      s_next.sel_pd = !control_port_mode_pin;
      s_next.dmic = s_next.pin_ctrl[pin_ctrl_dmic_bit];
   end

   // single state register; srst is power-on reset
   always_ff @(posedge core_clk) begin
      if (srst) begin
         s_reg <= '0;
         s_reg.state <= st_reset;
         s_reg.irq_n <= 1'b1;
         s_reg.gp_pd <= 3'h7;
         s_reg.gp5_pd <= 1'b1;
         s_reg.sel_pd <= 1'b1;
         s_reg.core_reset <= 1'b1;
      end else if (clk_en) begin
         s_reg <= s_next;
      end
   end

   assign prdata = s_reg.prdata;
   assign pready = s_reg.pready;
   assign pslverr = s_reg.pslverr;
   assign core_reset = s_reg.core_reset;
   assign sleep_mode = s_reg.sleep;
   assign boot_complete_flag = s_reg.flag;
   assign irq_n = s_reg.irq_n;
   assign general_pin_one_out = s_reg.gp1_out;
   assign general_pin_one_oe = s_reg.gp1_oe;
   assign general_pins_pd = s_reg.gp_pd;
   assign general_pin_five_pd = s_reg.gp5_pd;
   assign general_pin_five_oe = s_reg.gp5_oe;
   assign jtag_pd = 4'hf;
   assign regulator_enable_pin_pd = 1'b1;
   assign reset_pin_pu = 1'b1;
   assign control_port_select_pin_pd = s_reg.sel_pd;
   assign mic_dual_digital = s_reg.dmic;
endmodule // power_on_reset_boot_status

// file: tb/por_boot_checker_properties.sv
// Purpose: port-level checks for the por boot block
// Assumes: one clock domain, srst synchronous high
// Notes: clk_en is held high by the bench
`timescale 1ns/100ps
module por_boot_checker (
   input wire logic core_clk, // clock
   input wire logic srst, // reset
   input wire logic analog_supply_ok, // rail
   input wire logic io_supply_one_ok, // rail
   input wire logic control_port_mode_pin, // mode
   input wire logic psel, // apb
   input wire logic penable, // apb
   input wire logic pready, // apb
   input wire logic core_reset, // core held
   input wire logic sleep_mode, // sleep
   input wire logic boot_complete_flag, // flag
   input wire logic irq_n, // irq pin
   input wire logic [3:0] jtag_pd, // pulls
   input wire logic regulator_enable_pin_pd, // pull
   input wire logic reset_pin_pu, // pull
   input wire logic control_port_select_pin_pd // pull
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   // a lost analog or io rail must pull the core back into reset quickly
   chk_rail_loss: assert property (!(analog_supply_ok && io_supply_one_ok) |-> ##[1:2] core_reset)
      else $error("core runs without rails");
   chk_flag_held: assert property (core_reset |-> !boot_complete_flag)
      else $error("flag set in reset");
   chk_sleep_core: assert property (sleep_mode |-> core_reset)
      else $error("core live in sleep");
   chk_irq_cause: assert property ($fell(irq_n) |-> boot_complete_flag)
      else $error("irq fell without flag");
   chk_flag_boot: assert property ($rose(boot_complete_flag) |-> !$past(core_reset, 2))
      else $error("flag rose out of boot");
   chk_fixed_pulls: assert property (jtag_pd == 4'hf && regulator_enable_pin_pd && reset_pin_pu)
      else $error("fixed pull missing");
   // $past guard keeps the check off the first edge after reset
   chk_select_pull: assert property ($past(!srst) && $stable(control_port_mode_pin)
      |-> control_port_select_pin_pd == !control_port_mode_pin)
      else $error("select pull wrong");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready too long");
   chk_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
endmodule // por_boot_checker
bind power_on_reset_boot_status por_boot_checker i_chk (.*);

// file: tb/power_on_reset_boot_status_tb.sv
// Purpose: self-checking bench for por and boot status
// Assumes: apb byte address is four times the index
// Notes: clk_en tied high, so freeze is not exercised
`timescale 1ns/100ps
module power_on_reset_boot_status_tb;
   import por_boot_pkg::*;
   logic core_clk = 1'b0, srst = 1'b1, clk_en = 1'b1, control_port_mode_pin = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er, pready, pslverr, core_reset, sleep_mode;
   logic boot_complete_flag, irq_n, general_pin_one_out, general_pin_one_oe, general_pin_five_pd;
   logic general_pin_five_oe, regulator_enable_pin_pd, reset_pin_pu, control_port_select_pin_pd, mic_dual_digital;
   logic analog_supply_ok, io_supply_one_ok, core_supply_ok, hw_reset_n;
   logic [13:0] paddr = 14'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [1:0] pwr_cmd = 2'h0;
   logic [2:0] general_pins_pd;
   logic [3:0] jtag_pd;
   int num_errors = 0, checks_done = 0;
   // default pin picture, expected 13'h1ffc
   wire [12:0] pins = {jtag_pd, regulator_enable_pin_pd, reset_pin_pu, general_pins_pd, general_pin_five_pd,
      control_port_select_pin_pd, general_pin_one_oe, mic_dual_digital};
   power_on_reset_boot_status i_dut (.*);
   supply_ctrl_model i_pwr (.*);
   always #5 core_clk = ~core_clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // request held until pready is seen high, released at that rising edge
   task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      // pready and data are taken at the rising edge that samples pready high
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         num_errors++;
         $display("BAD %0t apb no ready", $time);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic power(input logic [1:0] cmd, input int cyc);
      @(posedge core_clk);
      pwr_cmd <= cmd;
      repeat (cyc) @(negedge core_clk);
   endtask
   task automatic wait_boot;
      for (int i = 0; i < 1200 && boot_complete_flag !== 1'b1; i++) @(negedge core_clk);
      if (boot_complete_flag !== 1'b1) begin
         num_errors++;
         $display("BAD %0t boot never done", $time);
      end
      @(negedge core_clk);
   endtask
   task automatic end_sim;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      num_errors++;
      end_sim();
   end
   initial begin
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      power(2'h0, 5);
      chk({core_reset, pins}, 32'h3ffc);
      power(2'h1, 500);
      chk(boot_complete_flag, 32'h0);
      apb(1'b0, raw_status_five_boot_addr, 32'h0);
      chk(rd, 32'h0);
      wait_boot();
      chk({boot_complete_flag, irq_n}, 32'h2);
      apb(1'b0, raw_status_five_boot_addr, 32'h0);
      chk(rd, 32'h100);
      apb(1'b0, pin_ctrl_addr, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h0ff, 32'h0);
      chk({er, rd[30:0]}, 32'h8000_0000);
      power(2'h1, 0);
      control_port_mode_pin <= 1'b1;
      repeat (3) @(negedge core_clk);
      chk(control_port_select_pin_pd, 32'h0);
      apb(1'b1, pin_ctrl_addr, 32'hf);
      apb(1'b1, pin_five_ctrl_addr, 32'h1);
      repeat (2) @(negedge core_clk);
      chk({general_pin_one_oe, general_pin_one_out, mic_dual_digital, general_pins_pd[0], irq_n}, 32'h1d);
      power(2'h2, 10);
      chk({sleep_mode, core_reset, boot_complete_flag}, 32'h6);
      power(2'h1, 0);
      wait_boot();
      chk({general_pin_five_oe, general_pin_one_oe, mic_dual_digital}, 32'h4);
      apb(1'b1, soft_reset_addr, 32'h0);
      repeat (2) @(negedge core_clk);
      chk({boot_complete_flag, general_pin_five_oe}, 32'h1);
      wait_boot();
      power(2'h3, 5);
      chk({boot_complete_flag, core_reset}, 32'h1);
      power(2'h1, 0);
      wait_boot();
      power(2'h0, 5);
      chk({core_reset, boot_complete_flag}, 32'h2);
      power(2'h1, 0);
      wait_boot();
      chk({boot_complete_flag, pins}, 32'h3ff8);
      end_sim();
   end
endmodule // power_on_reset_boot_status_tb

// file: tb/supply_ctrl_model.sv
// Purpose: host and rail model for the por boot block
// Assumes: rail-good levels are already threshold compared
// Notes: cmd 0 off, 1 on, 2 core rail off for sleep, 3 reset pin low
`timescale 1ns/100ps
module supply_ctrl_model (
   input wire logic core_clk, // clock
   input wire logic [1:0] pwr_cmd, // bench command
   output logic analog_supply_ok = 1'b0, // analog rail good
   output logic io_supply_one_ok = 1'b0, // io rail one good
   output logic core_supply_ok = 1'b0, // core rail good
   output logic hw_reset_n = 1'b1 // reset pin, low active
);
   // core rail drops in the sleep step and at power off; audio bus never made operational
   always @(posedge core_clk) begin
      analog_supply_ok <= pwr_cmd != 2'h0;
      io_supply_one_ok <= pwr_cmd != 2'h0;
      core_supply_ok <= pwr_cmd[0];
      hw_reset_n <= pwr_cmd != 2'h3;
   end
endmodule // supply_ctrl_model
